// *** core/bst_defs.svh ***
// Constants of the boundary-scan test port
`ifndef BST_DEFS_SVH
`define BST_DEFS_SVH

// ************************************************************
// Instruction register
// ************************************************************
`define BST_IR_W         4
`define BST_IR_EXTEST    4'h0
`define BST_IR_SAMPLE    4'h1
`define BST_IR_IDCODE    4'h2
`define BST_IR_BYPASS    4'hF
`define BST_IR_CAPTURE   4'h1
`define BST_IR_RESET     4'h2

// ************************************************************
// Identification register layout
// ************************************************************
`define BST_ID_W         32
`define BST_ID_VER_W     4
`define BST_ID_PART_W    16
`define BST_ID_MFR_W     11
`define BST_ID_VER_LSB   28
`define BST_ID_PART_LSB  12
`define BST_ID_MFR_LSB   1
`define BST_ID_LSB_VAL   1'h1

// ************************************************************
// Boundary chain
// ************************************************************
`define BST_BSR_LEN      8

`endif

// *** core/bst_pkg.sv ***
// Types of the boundary-scan test port
package bst_pkg;

  // ************************************************************
  // Test access controller states
  // ************************************************************
  typedef enum logic [3:0] {
    BST_TLR      = 4'h0,
    BST_RTI      = 4'h1,
    BST_SEL_DR   = 4'h2,
    BST_CAP_DR   = 4'h3,
    BST_SHIFT_DR = 4'h4,
    BST_EXIT1_DR = 4'h5,
    BST_PAUSE_DR = 4'h6,
    BST_EXIT2_DR = 4'h7,
    BST_UPD_DR   = 4'h8,
    BST_SEL_IR   = 4'h9,
    BST_CAP_IR   = 4'hA,
    BST_SHIFT_IR = 4'hB,
    BST_EXIT1_IR = 4'hC,
    BST_PAUSE_IR = 4'hD,
    BST_EXIT2_IR = 4'hE,
    BST_UPD_IR   = 4'hF
  } bst_tap_e;

  // ************************************************************
  // Data register selection
  // ************************************************************
  typedef enum logic [1:0] {
    BST_DR_BYPASS = 2'h0,
    BST_DR_ID     = 2'h1,
    BST_DR_BSR    = 2'h2
  } bst_dr_e;

endpackage

// *** core/bst_tap.sv ***
// Boundary-scan test access port, test pins sampled by the system clock
//
// Notes on behaviour
// - Mode select is taken at each test clock rise and steers the controller.
// - Mode select, data in and test reset idle high when undriven.
// - Serial data in is taken at the test clock rise.
// - Data in goes to instruction or selected data register by controller state.
// - While shifting, the active register leaves serially on data out.
// - Data out changes only at test clock falling edges and at test reset, which releases it.
// - Data out is released whenever no shift is in progress.
// - Test reset returns the controller to test-logic-reset and loads idcode into the instruction register.
// - Test logic never disturbs the functional core logic unless extest is current.
// - The instruction register is four bits wide.
// - Instruction bits shift in only in the instruction shift state; the current instruction loads at instruction update.
// - Current instruction picks the data register and its serial path.
// - Public instructions extest, sample/preload, idcode and bypass are decoded.
// - Exactly three data registers: boundary chain, bypass, identification.
// - Boundary cells form one serial chain around the core pins.
// - Bypass gives a one-bit path from data in to data out.
// - Identification: version 31:28, part 27:12, maker 11:1, bit 0 one.
`timescale 1ns/1ps
`include "bst_defs.svh"

module bst_tap #(
  parameter int                         BSR_LEN = `BST_BSR_LEN,
  parameter logic [`BST_ID_VER_W-1:0]   ID_VER  = 4'h1,    // Arbitrary value
  parameter logic [`BST_ID_PART_W-1:0]  ID_PART = 16'h1234, // Arbitrary value
  parameter logic [`BST_ID_MFR_W-1:0]   ID_MFR  = 11'h055   // Arbitrary value
) (
  input  wire logic                mclk_i,
  input  wire logic                rst_n_i,
  input  wire logic                tck_i,
  input  wire logic                tms_i,
  input  wire logic                tdi_i,
  input  wire logic                trst_n_i,
  input  wire logic [BSR_LEN-1:0]  core_pins_i,
  output logic                     tdo_o,
  output logic                     tdo_oe_n_o,
  output logic [BSR_LEN-1:0]       bsr_upd_o,
  output logic                     extest_o
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic                  tck_s1;
    logic                  tck_s2;
    logic                  tck_s3;
    logic                  tms_s1;
    logic                  tms_s2;
    logic                  tdi_s1;
    logic                  tdi_s2;
    logic                  trst_s1;
    logic                  trst_s2;
    bst_pkg::bst_tap_e     state;
    logic [`BST_IR_W-1:0]  ir;
    logic [`BST_IR_W-1:0]  ir_sh;
    logic [`BST_ID_W-1:0]  id_sh;
    logic                  byp;
    logic [BSR_LEN-1:0]    bsr_sh;
    logic [BSR_LEN-1:0]    bsr_upd;
    logic                  tdo;
    logic                  tdo_oe_n;
    logic                  extest;
  } bst_state_s;

  localparam logic [`BST_ID_W-1:0] ID_VALUE = {ID_VER, ID_PART, ID_MFR, `BST_ID_LSB_VAL};

  bst_state_s r;
  bst_state_s nxt;

  logic tck_rise;
  logic tck_fall;
  logic trst_act;

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic bst_pkg::bst_tap_e tap_next(input bst_pkg::bst_tap_e s,
                                                 input logic tms);
    bst_pkg::bst_tap_e n;
    case (s)
      bst_pkg::BST_TLR:      n = tms ? bst_pkg::BST_TLR      : bst_pkg::BST_RTI;
      bst_pkg::BST_RTI:      n = tms ? bst_pkg::BST_SEL_DR   : bst_pkg::BST_RTI;
      bst_pkg::BST_SEL_DR:   n = tms ? bst_pkg::BST_SEL_IR   : bst_pkg::BST_CAP_DR;
      bst_pkg::BST_CAP_DR:   n = tms ? bst_pkg::BST_EXIT1_DR : bst_pkg::BST_SHIFT_DR;
      bst_pkg::BST_SHIFT_DR: n = tms ? bst_pkg::BST_EXIT1_DR : bst_pkg::BST_SHIFT_DR;
      bst_pkg::BST_EXIT1_DR: n = tms ? bst_pkg::BST_UPD_DR   : bst_pkg::BST_PAUSE_DR;
      bst_pkg::BST_PAUSE_DR: n = tms ? bst_pkg::BST_EXIT2_DR : bst_pkg::BST_PAUSE_DR;
      bst_pkg::BST_EXIT2_DR: n = tms ? bst_pkg::BST_UPD_DR   : bst_pkg::BST_SHIFT_DR;
      bst_pkg::BST_UPD_DR:   n = tms ? bst_pkg::BST_SEL_DR   : bst_pkg::BST_RTI;
      bst_pkg::BST_SEL_IR:   n = tms ? bst_pkg::BST_TLR      : bst_pkg::BST_CAP_IR;
      bst_pkg::BST_CAP_IR:   n = tms ? bst_pkg::BST_EXIT1_IR : bst_pkg::BST_SHIFT_IR;
      bst_pkg::BST_SHIFT_IR: n = tms ? bst_pkg::BST_EXIT1_IR : bst_pkg::BST_SHIFT_IR;
      bst_pkg::BST_EXIT1_IR: n = tms ? bst_pkg::BST_UPD_IR   : bst_pkg::BST_PAUSE_IR;
      bst_pkg::BST_PAUSE_IR: n = tms ? bst_pkg::BST_EXIT2_IR : bst_pkg::BST_PAUSE_IR;
      bst_pkg::BST_EXIT2_IR: n = tms ? bst_pkg::BST_UPD_IR   : bst_pkg::BST_SHIFT_IR;
      bst_pkg::BST_UPD_IR:   n = tms ? bst_pkg::BST_SEL_DR   : bst_pkg::BST_RTI;
      default:               n = bst_pkg::BST_TLR;
    endcase
    return n;
  endfunction

  // Unknown codes fall back to bypass
  function automatic bst_pkg::bst_dr_e dr_sel(input logic [`BST_IR_W-1:0] ir);
    bst_pkg::bst_dr_e d;
    case (ir)
      `BST_IR_EXTEST: d = bst_pkg::BST_DR_BSR;
      `BST_IR_SAMPLE: d = bst_pkg::BST_DR_BSR;
      `BST_IR_IDCODE: d = bst_pkg::BST_DR_ID;
      default:        d = bst_pkg::BST_DR_BYPASS;
    endcase
    return d;
  endfunction

  // ************************************************************
  // Edge detection
  // ************************************************************
  assign tck_rise = r.tck_s2 & ~r.tck_s3;
  assign tck_fall = ~r.tck_s2 & r.tck_s3;
  assign trst_act = ~r.trst_s2;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt         = r;
    nxt.tck_s1  = tck_i;
    nxt.tck_s2  = r.tck_s1;
    nxt.tck_s3  = r.tck_s2;
    nxt.tms_s1  = tms_i;
    nxt.tms_s2  = r.tms_s1;
    nxt.tdi_s1  = tdi_i;
    nxt.tdi_s2  = r.tdi_s1;
    nxt.trst_s1 = trst_n_i;
    nxt.trst_s2 = r.trst_s1;

    if (trst_act) begin
      nxt.state    = bst_pkg::BST_TLR;
      nxt.ir       = `BST_IR_RESET;
      nxt.ir_sh    = `BST_IR_RESET;
      nxt.tdo_oe_n = 1'b1;
      nxt.extest   = 1'b0;
    end else if (tck_rise) begin
      nxt.state = tap_next(r.state, r.tms_s2);
      case (r.state)
        bst_pkg::BST_TLR: begin
          nxt.ir     = `BST_IR_RESET;
          nxt.extest = 1'b0;
        end
        bst_pkg::BST_CAP_IR: begin
          nxt.ir_sh = `BST_IR_CAPTURE;
        end
        bst_pkg::BST_SHIFT_IR: begin
          nxt.ir_sh = {r.tdi_s2, r.ir_sh[`BST_IR_W-1:1]};
        end
        bst_pkg::BST_UPD_IR: begin
          nxt.ir     = r.ir_sh;
          nxt.extest = (r.ir_sh == `BST_IR_EXTEST);
        end
        bst_pkg::BST_CAP_DR: begin
          case (dr_sel(r.ir))
            bst_pkg::BST_DR_ID:  nxt.id_sh  = ID_VALUE;
            bst_pkg::BST_DR_BSR: nxt.bsr_sh = core_pins_i;
            default:             nxt.byp    = 1'b0;
          endcase
        end
        bst_pkg::BST_SHIFT_DR: begin
          case (dr_sel(r.ir))
            bst_pkg::BST_DR_ID:  nxt.id_sh  = {r.tdi_s2, r.id_sh[`BST_ID_W-1:1]};
            bst_pkg::BST_DR_BSR: nxt.bsr_sh = {r.tdi_s2, r.bsr_sh[BSR_LEN-1:1]};
            default:             nxt.byp    = r.tdi_s2;
          endcase
        end
        bst_pkg::BST_UPD_DR: begin
          if (dr_sel(r.ir) == bst_pkg::BST_DR_BSR) begin
            nxt.bsr_upd = r.bsr_sh;
          end
        end
        default: begin
        end
      endcase
    end else if (tck_fall) begin
      case (r.state)
        bst_pkg::BST_SHIFT_IR: begin
          nxt.tdo      = r.ir_sh[0];
          nxt.tdo_oe_n = 1'b0;
        end
        bst_pkg::BST_SHIFT_DR: begin
          nxt.tdo_oe_n = 1'b0;
          case (dr_sel(r.ir))
            bst_pkg::BST_DR_ID:  nxt.tdo = r.id_sh[0];
            bst_pkg::BST_DR_BSR: nxt.tdo = r.bsr_sh[0];
            default:             nxt.tdo = r.byp;
          endcase
        end
        default: begin
          nxt.tdo_oe_n = 1'b1;
        end
      endcase
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // Mode select, data in and test reset samplers reset to the pulled-up idle level, test clock samplers low
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r.tck_s1   <= 1'b0;
      r.tck_s2   <= 1'b0;
      r.tck_s3   <= 1'b0;
      r.tms_s1   <= 1'b1;
      r.tms_s2   <= 1'b1;
      r.tdi_s1   <= 1'b1;
      r.tdi_s2   <= 1'b1;
      r.trst_s1  <= 1'b1;
      r.trst_s2  <= 1'b1;
      r.state    <= bst_pkg::BST_TLR;
      r.ir       <= `BST_IR_RESET;
      r.ir_sh    <= `BST_IR_RESET;
      r.id_sh    <= '0;
      r.byp      <= 1'b0;
      r.bsr_sh   <= '0;
      r.bsr_upd  <= '0;
      r.tdo      <= 1'b0;
      r.tdo_oe_n <= 1'b1;
      r.extest   <= 1'b0;
    end else begin
      r <= nxt;
    end
  end

  // Core pins only ever read, never forced, unless extest is current
  assign tdo_o      = r.tdo;
  assign tdo_oe_n_o = r.tdo_oe_n;
  assign bsr_upd_o  = r.bsr_upd;
  assign extest_o   = r.extest;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_rise_in(bst_pkg::bst_tap_e st);
    tck_rise && !trst_act && r.state == st;
  endsequence

  sequence s_fall_in(bst_pkg::bst_tap_e st);
    tck_fall && !trst_act && r.state == st;
  endsequence

  a_tdo_fall_only: assert property (
    $changed(r.tdo) || $changed(r.tdo_oe_n) |-> $past(tck_fall) || $past(trst_act))
    else $error("Data out moved outside a falling test clock edge");

  a_tdo_released: assert property (
    tck_fall && !trst_act && r.state != bst_pkg::BST_SHIFT_IR
      && r.state != bst_pkg::BST_SHIFT_DR |=> r.tdo_oe_n)
    else $error("Data out driven outside a shift");

  a_trst_clears: assert property (
    trst_act |=> r.state == bst_pkg::BST_TLR && r.ir == `BST_IR_RESET && r.tdo_oe_n)
    else $error("Test reset did not clear the controller");

  a_state_steps: assert property (
    tck_rise && !trst_act |=> r.state == tap_next($past(r.state), $past(r.tms_s2)))
    else $error("Controller did not follow mode select");

  a_state_holds: assert property (
    !tck_rise && !trst_act |=> $stable(r.state))
    else $error("Controller moved without a test clock rise");

  a_ir_shift: assert property (
    s_rise_in(bst_pkg::BST_SHIFT_IR) |=> r.ir_sh == {$past(r.tdi_s2), $past(r.ir_sh[3:1])})
    else $error("Instruction shift lost a bit");

  a_ir_update: assert property (
    !trst_act && !(tck_rise && (r.state == bst_pkg::BST_UPD_IR
      || r.state == bst_pkg::BST_TLR)) |=> $stable(r.ir))
    else $error("Instruction changed outside update");

  a_bypass_path: assert property (
    s_rise_in(bst_pkg::BST_SHIFT_DR) ##0 (dr_sel(r.ir) == bst_pkg::BST_DR_BYPASS)
      |=> r.byp == $past(r.tdi_s2))
    else $error("Bypass stage did not take data in");

  a_id_capture: assert property (
    s_rise_in(bst_pkg::BST_CAP_DR) ##0 (r.ir == `BST_IR_IDCODE)
      |=> r.id_sh == ID_VALUE && r.id_sh[0])
    else $error("Identification capture wrong");

  a_ir_out: assert property (
    s_fall_in(bst_pkg::BST_SHIFT_IR) |=> r.tdo == $past(r.ir_sh[0]) && !r.tdo_oe_n)
    else $error("Instruction bit not presented on data out");

endmodule

// *** tb/bst_ctl_model.sv ***
// Boundary-scan controller model that drives the test pins
`timescale 1ns/1ps
module bst_ctl_model (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      trst_n_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_n_i
);
  int bad_oe;
  initial begin
    tck_o    = 1'b0;
    tms_o    = 1'b1;
    tdi_o    = 1'b1;
    trst_n_o = 1'b0;
    bad_oe   = 0;
  end
  // ****************************
  // Pin sequences
  // ****************************
  // One test clock period, data out taken just before the rise
  task automatic tick(input logic ms, input logic di, output logic dq, output logic oen);
    tms_o = ms;
    tdi_o = di;
    #62.5;
    dq    = tdo_i;
    oen   = tdo_oe_n_i;
    tck_o = 1'b1;
    #62.5;
    tck_o = 1'b0;
  endtask
  task automatic set_trst(input logic v);
    trst_n_o = v;
  endtask
  // Five rises with mode select high reach reset from any state
  task automatic reset_tap();
    logic q, e;
    repeat (5) tick(1'b1, 1'b1, q, e);
  endtask
  // Idle, select, capture, then n bits into the shift state
  task automatic enter_shift(input logic ir, input int n);
    logic q, e;
    tick(1'b0, 1'b1, q, e);
    if (e !== 1'b1) bad_oe++;
    tick(1'b1, 1'b1, q, e);
    if (ir) tick(1'b1, 1'b1, q, e);
    tick(1'b0, 1'b1, q, e);
    tick(1'b0, 1'b1, q, e);
    repeat (n) tick(1'b0, 1'b0, q, e);
  endtask
  // Full scan, LSB first, ends in idle with pins at pull-up level
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    logic q, e;
    dout = '0;
    enter_shift(ir, 0);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], dout[i], e);
      if (e !== 1'b0) bad_oe++;
    end
    tick(1'b1, 1'b1, q, e);
    if (e !== 1'b1) bad_oe++;
    tick(1'b0, 1'b1, q, e);
    tms_o = 1'b1;
    tdi_o = 1'b1;
  endtask
endmodule

// *** tb/bst_tap_tb.sv ***
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`include "bst_defs.svh"
module bst_tap_tb;
  localparam int                        BSR_LEN = 8;
  localparam logic [`BST_ID_VER_W-1:0]  ID_VER  = 4'h3;     // Arbitrary value
  localparam logic [`BST_ID_PART_W-1:0] ID_PART = 16'h5A5A; // Arbitrary value
  localparam logic [`BST_ID_MFR_W-1:0]  ID_MFR  = 11'h2C3;  // Arbitrary value
  localparam logic [31:0]               ID_VAL  = {ID_VER, ID_PART, ID_MFR, 1'h1};
  logic               mclk = 1'b0;
  logic               rst_n = 1'b0;
  logic [BSR_LEN-1:0] core_pins = 8'h00;
  wire                tck, tms, tdi, trst_n;
  logic               tdo, tdo_oe_n, extest;
  logic [BSR_LEN-1:0] bsr_upd;
  logic [1:0]         held;
  int                 fail_count = 0;
  int                 checks_done = 0;
  int                 cycles = 0;

  bst_tap #(.BSR_LEN(BSR_LEN), .ID_VER(ID_VER), .ID_PART(ID_PART), .ID_MFR(ID_MFR)) DUT (
    .mclk_i(mclk), .rst_n_i(rst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .trst_n_i(trst_n), .core_pins_i(core_pins), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n),
    .bsr_upd_o(bsr_upd), .extest_o(extest));
  bst_ctl_model ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .trst_n_o(trst_n),
    .tdo_i(tdo), .tdo_oe_n_i(tdo_oe_n));

  always #5 mclk = ~mclk;
  // ****************************
  // Checking and closing
  // ****************************
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  // Data out must not move while the test clock is high
  always @(posedge tck) held = {tdo_oe_n, tdo};
  always @(negedge tck) chk("tdo high phase", held, {tdo_oe_n, tdo});
  // ****************************
  // Scenarios
  // ****************************
  task automatic t_idcode();
    logic [63:0] d;
    chk("tdo_oe_n_o idle", 1, tdo_oe_n);
    chk("extest_o reset", 0, extest);
    chk("bsr_upd_o reset", 0, bsr_upd);
    ctl.scan(1'b0, 40, 64'h0000_0000_0000_00C3, d);
    chk("id after reset", {8'hC3, ID_VAL}, d);
    chk("oe framing", 0, ctl.bad_oe);
    $display("t_idcode done");
  endtask
  task automatic t_codes();
    logic [3:0]  codes [5];
    logic [63:0] din, d, exp;
    codes = '{`BST_IR_EXTEST, `BST_IR_SAMPLE, `BST_IR_IDCODE, `BST_IR_BYPASS, 4'h7};
    for (int k = 0; k < 5; k++) begin
      din = {24'h0, 40'hA53C96E11D ^ 40'(k * 7)};
      @(negedge mclk) core_pins = 8'h5A ^ 8'(k);
      ctl.scan(1'b1, 4, {60'h0, codes[k]}, d);
      chk("ir capture", 64'h1, d);
      chk("extest_o", (k == 0), extest);
      ctl.scan(1'b0, 40, din, d);
      case (k)
        0, 1: exp = {din[31:0], core_pins};
        2: exp = {din[7:0], ID_VAL};
        default: exp = {din[38:0], 1'b0};
      endcase
      chk("dr path", exp, d);
      if (k < 2) chk("bsr_upd_o", din[39:32], bsr_upd);
    end
    chk("oe framing", 0, ctl.bad_oe);
    $display("t_codes done");
  endtask
  task automatic t_tms_reset();
    logic [63:0] d;
    ctl.scan(1'b1, 4, {60'h0, `BST_IR_BYPASS}, d);
    ctl.enter_shift(1'b0, 3);
    ctl.reset_tap();
    #100;
    chk("tdo_oe_n_o after reset", 1, tdo_oe_n);
    ctl.scan(1'b0, 32, 64'h0, d);
    chk("id after tms reset", ID_VAL, d);
    $display("t_tms_reset done");
  endtask
  task automatic t_trst();
    logic [63:0] d;
    ctl.scan(1'b1, 4, {60'h0, `BST_IR_EXTEST}, d);
    chk("extest_o loaded", 1, extest);
    ctl.enter_shift(1'b0, 5);
    ctl.set_trst(1'b0);
    #200;
    chk("tdo_oe_n_o test reset", 1, tdo_oe_n);
    chk("extest_o test reset", 0, extest);
    ctl.set_trst(1'b1);
    #100;
    ctl.scan(1'b0, 32, 64'h0, d);
    chk("id after test reset", ID_VAL, d);
    $display("t_trst done");
  endtask
  // Identification read split by a pause, exit2 back into shift
  task automatic t_pause();
    logic [63:0] d;
    logic        q, e;
    d = '0;
    ctl.enter_shift(1'b0, 0);
    for (int i = 0; i < 32; i++) begin
      ctl.tick(i == 15 || i == 31, 1'b0, d[i], e);
      if (i == 15) begin
        ctl.tick(1'b0, 1'b0, q, e);
        chk("tdo_oe_n_o pause", 1, e);
        ctl.tick(1'b0, 1'b0, q, e);
        ctl.tick(1'b1, 1'b0, q, e);
        ctl.tick(1'b0, 1'b0, q, e);
      end
    end
    ctl.tick(1'b1, 1'b1, q, e);
    ctl.tick(1'b0, 1'b1, q, e);
    chk("id across pause", ID_VAL, d);
    ctl.reset_tap();
    $display("t_pause done");
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    @(negedge mclk) rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    ctl.set_trst(1'b1);
    #100;
    t_idcode();
    t_codes();
    t_tms_reset();
    t_trst();
    t_pause();
    complete_run();
  end
endmodule
